// File: rtl/aic_regs.vh
// Purpose: Register map, field positions and timing constants of the converter control block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: Included by the control block and the testbench
`ifndef AIC_REGS_VH
`define AIC_REGS_VH
// Byte offsets
`define AIC_CTRL_OFS 8'h00
`define AIC_SRC_OFS 8'h04
`define AIC_RES_OFS 8'h08
`define AIC_MODE_OFS 8'h0C
`define AIC_IRQ_STAT_OFS 8'h10
`define AIC_IRQ_MASK_OFS 8'h14
// Control register fields
`define AIC_CTRL_START 7
`define AIC_CTRL_BUSY 6
`define AIC_CTRL_EN 5
`define AIC_CTRL_FMT 4
// Source / reference / clock register fields
`define AIC_SRC_INS_HI 7
`define AIC_SRC_INS_LO 5
`define AIC_SRC_REF_HI 4
`define AIC_SRC_REF_LO 3
`define AIC_SRC_CKS_HI 2
`define AIC_SRC_CKS_LO 0
// Reset values
`define AIC_CTRL_RST 8'h00
`define AIC_SRC_RST 8'h00
// Conversion timing in converter clocks, and conversions per accumulation
`define AIC_SAMPLE_CYC 5'h04
`define AIC_CONV_CYC 5'h0C
`define AIC_TOTAL_CYC 5'h10
`define AIC_ACC_COUNT 5'h10
// Input source and reference codes
`define AIC_INS_AMP2 3'h1
`define AIC_INS_FILT 3'h2
`define AIC_INS_AMP1 3'h3
`define AIC_INS_BATT 3'h4
`define AIC_REF_REG 2'h1
`endif

// File: rtl/aic_clk_div.v
// Purpose: Power-of-two prescaler giving a one-cycle converter clock tick
// Assumes: Divider code 0..7 selects division by 1..128
// Notes: Counter restarts when the converter is held idle
`timescale 1ns/100ps
`default_nettype none
module aic_clk_div (
  input wire clk, // System clock
  input wire rstn, // Synchronous reset, active low
  input wire run, // Count while high
  input wire [2:0] sel, // Division exponent
  output wire tick // One pulse per converter clock
);
  reg [6:0] cnt_ff;
  wire [6:0] nxt_cnt;
  wire [6:0] limit;

  // Terminal count is two to the power of sel, minus one
  assign limit = (7'h01 << sel) - 7'h01;
  assign tick = run && (cnt_ff == limit);
  assign nxt_cnt = (!run || tick) ? 7'h00 : cnt_ff + 7'h01;

  // Free counter, cleared when idle so each conversion starts aligned
  always @(posedge clk)
  begin
    if (!rstn)
      cnt_ff <= 7'h00;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule
`default_nettype wire

// File: rtl/aic_ctrl.v
// Purpose: Converter control: source/reference select, prescaler, start/busy, result, interrupt
// Assumes: AXI4-Lite slave, 20 MHz clk, analog converter supplies one result bit per clock
// Notes: Analog macro is modelled as a successive-approximation bit stream on sar_bit
`timescale 1ns/100ps
`default_nettype none
`include "aic_regs.vh"
module aic_ctrl (
  input wire clk, // System clock, 20 MHz
  input wire rstn, // Synchronous reset, active low
  input wire [7:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output wire [1:0] s_axi_bresp, // Write response
  output wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [7:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output wire [31:0] s_axi_rdata, // Read data
  output wire [1:0] s_axi_rresp, // Read response
  output wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire sar_bit, // Comparator decision from analog core
  output wire [3:0] external_channel_sel, // External channel to analog mux
  output wire [2:0] internal_source_sel, // One-hot-free internal source code, 0 = none
  output wire ext_input_route, // External channel routed to converter
  output wire regulator_output_ref, // Reference from regulator when high
  output wire conv_power, // Converter circuitry powered
  output wire conv_reset, // Converter held in reset
  output wire conv_sample, // Sampling phase active
  output wire conv_clk_tick, // Converter clock tick
  output wire irq // Level interrupt
);
  // State machine, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [7:0] ctrl_ff;
  reg [7:0] src_ff;
  reg acc_mode_ff;
  reg [15:0] result_ff;
  reg [11:0] sar_ff;
  reg [15:0] acc_ff;
  reg [4:0] cyc_ff;
  reg [4:0] nconv_ff;
  reg [2:0] state_ff;
  reg start_seen_ff;
  reg busy_ff;
  reg irq_stat_ff;
  reg irq_mask_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  wire tick;
  wire start_bit;
  wire enable_bit;
  wire begin_conv;
  wire conv_done;
  wire wr_go;
  wire rd_go;
  wire wr_hit;
  wire clear_start;
  wire [2:0] ins;
  wire running;

  // Byte-lane merge used for the control and source registers
  function [7:0] lane0;
    input [7:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      lane0 = strb[0] ? data[7:0] : old;
    end
  endfunction

  // Address decoder shared by read and write paths
  function mapped;
    input [7:0] a;
    begin
      if (a == `AIC_CTRL_OFS)
        mapped = 1'b1;
      else if (a == `AIC_SRC_OFS)
        mapped = 1'b1;
      else if (a == `AIC_RES_OFS)
        mapped = 1'b1;
      else if (a == `AIC_MODE_OFS)
        mapped = 1'b1;
      else if (a == `AIC_IRQ_STAT_OFS)
        mapped = 1'b1;
      else if (a == `AIC_IRQ_MASK_OFS)
        mapped = 1'b1;
      else
        mapped = 1'b0;
    end
  endfunction

  assign start_bit = ctrl_ff[`AIC_CTRL_START];
  assign enable_bit = ctrl_ff[`AIC_CTRL_EN];
  assign ins = src_ff[`AIC_SRC_INS_HI:`AIC_SRC_INS_LO];

  // Analog routing from the select fields
  assign ext_input_route = (ins == 3'h0) || (ins > `AIC_INS_BATT);
  assign internal_source_sel = ext_input_route ? 3'h0 : ins;
  assign external_channel_sel = ctrl_ff[3:0];
  assign regulator_output_ref = (src_ff[`AIC_SRC_REF_HI:`AIC_SRC_REF_LO] == `AIC_REF_REG);
  assign conv_power = enable_bit;
  assign conv_reset = start_bit | ~enable_bit;
  assign conv_clk_tick = tick;
  // Gated by the hold so no tick or sampling leaks out in the cycle a write stops a run
  assign running = state_ff[1] && enable_bit && !start_bit;
  assign conv_sample = running && (cyc_ff < `AIC_SAMPLE_CYC);

  // Prescaler runs only while a conversion is under way
  aic_clk_div u_div (
    .clk(clk),
    .rstn(rstn),
    .run(running),
    .sel(src_ff[`AIC_SRC_CKS_HI:`AIC_SRC_CKS_LO]),
    .tick(tick)
  );

  // Bus handshake: address and data taken independently
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_hit = wr_go && mapped(awaddr_ff);
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign rd_go = s_axi_arvalid && !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Start detection: falling edge of start after it was seen high
  assign clear_start = start_seen_ff && !start_bit;
  assign begin_conv = clear_start && enable_bit && state_ff[0];
  assign conv_done = state_ff[1] && tick && (cyc_ff == `AIC_TOTAL_CYC - 5'h01)
    && (!acc_mode_ff || nconv_ff == `AIC_ACC_COUNT - 5'h01);

  assign irq = irq_stat_ff && irq_mask_ff;

  // Write channel capture and response
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= mapped(awaddr_ff) ? 2'h0 : 2'h2;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // Read channel; unmapped addresses answer SLVERR with zero data
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end
    else if (rd_go)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      if (s_axi_araddr == `AIC_CTRL_OFS)
        rdata_ff <= {24'h000000, ctrl_ff[7], busy_ff, ctrl_ff[5:0]};
      else if (s_axi_araddr == `AIC_SRC_OFS)
        rdata_ff <= {24'h000000, src_ff};
      else if (s_axi_araddr == `AIC_RES_OFS)
        rdata_ff <= {16'h0000, result_ff};
      else if (s_axi_araddr == `AIC_MODE_OFS)
        rdata_ff <= {31'h00000000, acc_mode_ff};
      else if (s_axi_araddr == `AIC_IRQ_STAT_OFS)
        rdata_ff <= {31'h00000000, irq_stat_ff};
      else if (s_axi_araddr == `AIC_IRQ_MASK_OFS)
        rdata_ff <= {31'h00000000, irq_mask_ff};
      else
        rdata_ff <= 32'h0000_0000;
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // Software registers; busy bit of control is never stored from the bus
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_ff <= `AIC_CTRL_RST;
      src_ff <= `AIC_SRC_RST;
      acc_mode_ff <= 1'b0;
      irq_mask_ff <= 1'b0;
    end
    else if (wr_hit)
    begin
      if (awaddr_ff == `AIC_CTRL_OFS)
        ctrl_ff <= lane0(ctrl_ff, wdata_ff, wstrb_ff) & 8'hBF;
      else if (awaddr_ff == `AIC_SRC_OFS)
        src_ff <= lane0(src_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `AIC_MODE_OFS && wstrb_ff[0])
        acc_mode_ff <= wdata_ff[0];
      else if (awaddr_ff == `AIC_IRQ_MASK_OFS && wstrb_ff[0])
        irq_mask_ff <= wdata_ff[0];
    end
  end

  // Start sequence tracker: remembers a high start bit until it drops
  always @(posedge clk)
  begin
    if (!rstn)
      start_seen_ff <= 1'b0;
    else if (start_bit)
      start_seen_ff <= 1'b1;
    else
      start_seen_ff <= 1'b0;
  end

  // Conversion sequencer
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      cyc_ff <= 5'h00;
      nconv_ff <= 5'h00;
      sar_ff <= 12'h000;
      acc_ff <= 16'h0000;
      result_ff <= 16'h0000;
    end
    else if (start_bit || !enable_bit)
    begin
      // Held in reset; result registers keep their contents
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      cyc_ff <= 5'h00;
      nconv_ff <= 5'h00;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (begin_conv)
          begin
            state_ff <= ST_RUN;
            busy_ff <= 1'b1;
            cyc_ff <= 5'h00;
            nconv_ff <= 5'h00;
            acc_ff <= 16'h0000;
            sar_ff <= 12'h000;
          end
        end
        ST_RUN:
        begin
          if (tick)
          begin
            // Conversion phase shifts in one decision per clock, MSB first
            if (cyc_ff >= `AIC_SAMPLE_CYC)
              sar_ff <= {sar_ff[10:0], sar_bit};
            if (cyc_ff == `AIC_TOTAL_CYC - 5'h01)
            begin
              cyc_ff <= 5'h00;
              nconv_ff <= nconv_ff + 5'h01;
              acc_ff <= acc_ff + {4'h0, sar_ff[10:0], sar_bit};
              if (conv_done)
                state_ff <= ST_DONE;
            end
            else
              cyc_ff <= cyc_ff + 5'h01;
          end
        end
        ST_DONE:
        begin
          // Result formatted once so reads see a stable word
          if (acc_mode_ff)
            result_ff <= acc_ff;
          else if (ctrl_ff[`AIC_CTRL_FMT])
            result_ff <= {4'h0, sar_ff};
          else
            result_ff <= {sar_ff, 4'h0};
          busy_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // Completion flag: set wins over write-one-to-clear
  always @(posedge clk)
  begin
    if (!rstn)
      irq_stat_ff <= 1'b0;
    else if (state_ff[2] && enable_bit && !start_bit)
      irq_stat_ff <= 1'b1;
    else if (wr_hit && awaddr_ff == `AIC_IRQ_STAT_OFS && wstrb_ff[0] && wdata_ff[0])
      irq_stat_ff <= 1'b0;
  end
endmodule
`default_nettype wire

// File: verif/aic_ctrl_assertions.sv
// Purpose: Timing checks on the converter control outputs
// Assumes: One clock, synchronous active-low reset
// Notes: Register contents are judged by the bench, not here
`timescale 1ns/100ps
`default_nettype none
module aic_ctrl_chk (
  input wire logic clk, // System clock
  input wire logic rstn, // Reset, active low
  input wire logic [2:0] internal_source_sel, // Internal source code
  input wire logic ext_input_route, // External route
  input wire logic conv_power, // Converter powered
  input wire logic conv_reset, // Converter held
  input wire logic conv_sample, // Sampling phase
  input wire logic conv_clk_tick // Converter clock tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [4:0] smp_ff;
  logic [4:0] gap_ff;
  logic seen_ff;
  // Ticks per phase; cleared while held so an abort starts fresh
  always @(posedge clk)
  begin
    if (!rstn || conv_reset)
    begin
      smp_ff <= 5'h00;
      gap_ff <= 5'h00;
      seen_ff <= 1'b0;
    end
    else
    begin
      smp_ff <= conv_sample ? smp_ff + {4'h0, conv_clk_tick} : 5'h00;
      gap_ff <= conv_sample ? 5'h00 : gap_ff + {4'h0, conv_clk_tick};
      if ($fell(conv_sample))
        seen_ff <= 1'b1;
    end
  end
  property p_route; ext_input_route == (internal_source_sel == 3'h0); endproperty
  a_route: assert property (p_route) else $error("route and source disagree");
  property p_srcmax; internal_source_sel <= 3'h4; endproperty
  a_srcmax: assert property (p_srcmax) else $error("source code too big");
  property p_pwr; !conv_power |-> conv_reset; endproperty
  a_pwr: assert property (p_pwr) else $error("unpowered but not held");
  property p_tick; conv_clk_tick |-> conv_power; endproperty
  a_tick: assert property (p_tick) else $error("tick while unpowered");
  property p_idle; conv_reset [*2] |-> !conv_sample && !conv_clk_tick; endproperty
  a_idle: assert property (p_idle) else $error("activity while held");
  property p_samp; $fell(conv_sample) && !conv_reset |-> smp_ff == 5'h04; endproperty
  a_samp: assert property (p_samp) else $error("sampling not 4 ticks");
  property p_gap; $rose(conv_sample) && seen_ff |-> gap_ff == 5'h0C; endproperty
  a_gap: assert property (p_gap) else $error("converting not 12 ticks");
  property p_rise; $rose(conv_sample) |-> !conv_reset && conv_power; endproperty
  a_rise: assert property (p_rise) else $error("sampling while held");
endmodule
bind aic_ctrl aic_ctrl_chk u_aic_ctrl_chk (.clk, .rstn, .internal_source_sel,
  .ext_input_route, .conv_power, .conv_reset, .conv_sample, .conv_clk_tick);
`default_nettype wire

// File: verif/test_adc_input_ref_clock_control.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: AXI4-Lite master driven at rising edges, bready and rready held high
// Notes: Analog core replaced by a bit stream of a random value
`timescale 1ns/100ps
`default_nettype none
`include "aic_regs.vh"
module test_adc_input_ref_clock_control;
  logic clk = 1'b0, rstn = 1'b0, sar_bit = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [1:0] rr;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] external_channel_sel;
  wire [2:0] internal_source_sel;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire ext_input_route, regulator_output_ref, conv_power, conv_reset;
  wire conv_sample, conv_clk_tick, irq;
  integer n_mismatch = 0, checked = 0, cyc = 0, k = 0, n_tick = 0, last = 0;
  integer i, j, f, e, t0, div = 0, val = 0;
  integer exp_q[$];

  aic_ctrl u_aic_ctrl (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sar_bit,
    .external_channel_sel, .internal_source_sel, .ext_input_route,
    .regulator_output_ref, .conv_power, .conv_reset, .conv_sample, .conv_clk_tick, .irq);

  // Clock, 50 ns period
  initial forever #25 clk = ~clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task results;
    begin
      $display("counts: %0d checked, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    begin
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w)
      begin
        @(posedge clk);
        if (aw && s_axi_awready)
        begin
          aw = 1'b0;
          s_axi_awvalid <= 1'b0;
        end
        if (w && s_axi_wready)
        begin
          w = 1'b0;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (!s_axi_bvalid)
        @(posedge clk);
      rr = s_axi_bresp;
    end
  endtask

  task rd(input logic [7:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge clk);
      while (!s_axi_arready)
        @(posedge clk);
      s_axi_arvalid <= 1'b0;
      @(posedge clk);
      while (!s_axi_rvalid)
        @(posedge clk);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
    end
  endtask

  // Ceiling well above the longest accumulation run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end

  // Analog core: MSB first over conversion ticks; also tick count and spacing
  always @(posedge clk)
  begin
    if (conv_reset || conv_sample)
    begin
      k <= 0;
      sar_bit <= val[11];
    end
    else if (conv_clk_tick && k < 11)
    begin
      k <= k + 1;
      sar_bit <= val[10 - k];
    end
    if (conv_clk_tick)
    begin
      n_tick <= n_tick + 1;
      if (last > 0)
        chk(cyc - last, 1 << div);
      last <= cyc;
    end
    if (conv_reset)
      last <= 0;
  end

  // Main sequence
  initial
  begin
    val = $urandom(33183);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(32'(conv_reset), 1);
    rd(`AIC_CTRL_OFS);
    chk(rv, 0);
    rd(`AIC_SRC_OFS);
    chk(rv, 0);
    rd(8'h40);
    chk(32'(rr), 2);
    wr(8'h40, 32'h1);
    chk(32'(rr), 2);
    $display("test reset and map done");
    // Park the external channel before any internal source
    wr(`AIC_CTRL_OFS, 32'h0F);
    chk(32'(external_channel_sel), 15);
    for (i = 0; i < 8; i++)
    begin
      // Random offset, yet every reference code appears within four passes
      f = (i + val[1:0]) % 4;
      // Bench never claims the reference pin while the regulator is chosen
      wr(`AIC_SRC_OFS, i * 32 + f * 8 + 3);
      chk(32'(ext_input_route), i == 0 || i > 4);
      chk(32'(internal_source_sel), (i > 0 && i < 5) ? i : 0);
      chk(32'(regulator_output_ref), f == 1);
      rd(`AIC_SRC_OFS);
      chk(rv, i * 32 + f * 8 + 3);
    end
    $display("test source decode done");
    // Divider, format, mode and mask from a small table
    for (j = 0; j < 3; j++)
    begin
      // Codes 4 to 6 keep the converter clock between 0.5 and 10 us at 20 MHz
      div = j + 4;
      f = (j % 2) * 16;
      val = $urandom % 4096;
      e = (j == 2) ? val * 16 : (f ? val : val * 16);
      exp_q.push_back(e);
      wr(`AIC_SRC_OFS, div);
      wr(`AIC_MODE_OFS, j == 2);
      wr(`AIC_IRQ_MASK_OFS, j != 1);
      wr(`AIC_CTRL_OFS, 32'h20 | f);
      chk(32'(conv_power), 1);
      repeat (20) @(posedge clk);
      wr(`AIC_CTRL_OFS, 32'hA0 | f);
      chk(32'(conv_reset), 1);
      t0 = n_tick;
      wr(`AIC_CTRL_OFS, 32'h20 | f);
      repeat (3) @(posedge clk);
      rd(`AIC_CTRL_OFS);
      chk(rv, 32'h60 | f);
      i = 0;
      while (rv[6] && i < 12000)
      begin
        rd(`AIC_CTRL_OFS);
        i = i + 1;
      end
      chk(rv, 32'h20 | f);
      chk(n_tick - t0, (j == 2) ? 256 : 16);
      rd(`AIC_RES_OFS);
      chk(rv, exp_q.pop_front());
      rd(`AIC_IRQ_STAT_OFS);
      chk(rv, 1);
      chk(32'(irq), j != 1);
      if (j == 1)
      begin
        wr(`AIC_IRQ_MASK_OFS, 1);
        chk(32'(irq), 1);
      end
      wr(`AIC_IRQ_STAT_OFS, 1);
      chk(32'(irq), 0);
      $display("test conversion %0d done", j);
    end
    // Abort mid-run, then a start pulse while disabled
    wr(`AIC_MODE_OFS, 0);
    wr(`AIC_CTRL_OFS, 32'hA0);
    wr(`AIC_CTRL_OFS, 32'h20);
    repeat (30) @(posedge clk);
    wr(`AIC_CTRL_OFS, 32'hA0);
    chk(32'(conv_reset), 1);
    wr(`AIC_CTRL_OFS, 32'h80);
    chk(32'(conv_power), 0);
    wr(`AIC_CTRL_OFS, 32'h00);
    repeat (8) @(posedge clk);
    rd(`AIC_CTRL_OFS);
    chk(rv, 0);
    rd(`AIC_RES_OFS);
    chk(rv, e);
    rd(`AIC_IRQ_STAT_OFS);
    chk(rv, 0);
    $display("test abort and disabled start done");
    results;
  end
endmodule
`default_nettype wire
